// File: src/adcb_backend.sv
// Mono ADC digital back end with microphone port and DC measurement
//
// What this block and its software must do
// R1: One 32-bit word pair each sample period
// R2: Left and right words carry same sample
// R3: Words truncated to configured word length
// R4: Selector 1010 drives modulator clock on pin
// R5: Microphone returns one-bit stream on data pin
// R6: Microphone bit captured at modulator clock rise
// R7: Microphone mode bypasses analog; ratio sets decimation
// R8: Software mutes before changing filter coefficients
// R9: Control bit enables DC measurement mode
// R10: Measure only while recording is idle
// R11: Result is signed 24-bit 2.22 value
// R12: Result readable in three byte registers
// R13: Freeze bit holds result for reading
// R14: Software clears freeze bit after reading
// R15: Type bit selects averaging or IIR
// R16: Length field 1..20 sets averaging over 2^length samples
// R17: Same field sets IIR coefficient
// R18: Periodic averaging reset every 2^R periods
// R19: Length should stay below reset exponent
// R20: Reset disabled means averaging never resets
// R21: Decimate oversampled stream to sample rate
// R22: Average output is mean of recent samples
// R23: Coefficient update order mute, wait, write, unmute
`timescale 1ns/100ps
module adcb_backend (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Modulator sources
    input wire logic adc_mod_bit,
    input wire logic serial_data_in,
    // Multifunction pin
    output logic multifunction_pin_one_out,
    output logic multifunction_pin_one_oe,
    // Analog front end bypass
    output logic analog_bypass,
    // Serial interface words
    output adcb_pkg::adcb_pair_type asi_words,
    output logic asi_valid
);

    // Pin selector field
    logic [3:0] pin_sel;
    // Measurement settings
    adcb_pkg::adcb_dc_cfg_type dc_cfg;
    // Freeze bit
    logic freeze;
    // Word length code and oversampling ratio
    logic [1:0] wlen;
    logic [9:0] adc_oversampling_ratio;
    // Frozen copy of the result
    logic [23:0] held;
    // Live filter output
    logic [23:0] dc_result;
    // Modulator clock divider
    logic [7:0] div_cnt;
    logic modulator_clock;
    // Data pin synchroniser
    logic din_meta;
    logic din_sync;
    // Decimator
    logic [10:0] dec_cnt;
    logic signed [11:0] dec_acc;

    // Register decode
    wire [9:0] reg_idx = paddr[11:2];
    wire hit_pin = reg_idx == adcb_pkg::IDX_PIN_SEL;
    wire hit_dc = reg_idx == adcb_pkg::IDX_DC_CTRL;
    wire hit_latch = reg_idx == adcb_pkg::IDX_DC_LATCH;
    wire hit_hi = reg_idx == adcb_pkg::IDX_RES_HI;
    wire hit_mid = reg_idx == adcb_pkg::IDX_RES_MID;
    wire hit_lo = reg_idx == adcb_pkg::IDX_RES_LO;
    wire hit_cfg = reg_idx == adcb_pkg::IDX_ADC_CFG;
    wire reg_hit = hit_pin | hit_dc | hit_latch | hit_hi | hit_mid |
        hit_lo | hit_cfg;
    // Access phase waits one cycle so that pready comes from a flop
    wire apb_access = psel & penable & ~pready;
    // Writes land at the edge where pready is sampled high
    wire wr_go = psel & penable & pready & pwrite & reg_hit;
    wire wr_lane0 = wr_go & pstrb[0];

    // Read data per register; unused bits read zero
    wire [31:0] rd_pin = {24'h0, 2'h0, pin_sel, 2'h0};
    wire [31:0] rd_dc = {24'h0, dc_cfg.enable, 1'b0, dc_cfg.iir,
        dc_cfg.len};
    wire [31:0] rd_latch = {24'h0, 1'b0, freeze, dc_cfg.prst_en,
        dc_cfg.prst_exp};
    wire [31:0] rd_hi = {24'h0, held[23:16]}; // [R12]
    wire [31:0] rd_mid = {24'h0, held[15:8]}; // [R12]
    wire [31:0] rd_lo = {24'h0, held[7:0]}; // [R12]
    wire [31:0] rd_cfg = {6'h0, adc_oversampling_ratio, 12'h0, wlen,
        1'b0, analog_bypass};
    wire [31:0] rd_mux = hit_pin ? rd_pin :
        hit_dc ? rd_dc :
        hit_latch ? rd_latch :
        hit_hi ? rd_hi :
        hit_mid ? rd_mid :
        hit_lo ? rd_lo :
        hit_cfg ? rd_cfg : 32'h0;

    // Modulator clock divider from the core clock
    wire div_done = div_cnt == (adcb_pkg::MOD_HALF_CYC - 8'h01);
    wire next_modulator_clock = div_done ? ~modulator_clock :
        modulator_clock;
    // One-cycle pulse at each rising edge of the modulator clock
    wire mod_rise = div_done & ~modulator_clock;
    wire pin_drives_clk = pin_sel == adcb_pkg::PIN_SEL_MODCLK;

    // Bit source: microphone stream or analog modulator
    wire mod_bit = analog_bypass ? din_sync : adc_mod_bit; // [R7] [R5]

    // Decimation ratio; zero stands for the largest ratio
    wire [10:0] osr_eff = (adc_oversampling_ratio == 10'h0) ?
        adcb_pkg::OSR_ZERO_MEANS : {1'b0, adc_oversampling_ratio};
    // At-least compare: lowering the ratio mid-count cannot stall
    wire dec_done = dec_cnt >= (osr_eff - 11'h001); // [R21] [R7]
    wire signed [11:0] step = mod_bit ? 12'sh001 : 12'shfff;
    wire signed [11:0] next_dec_acc = dec_acc + step;
    // Sample placed at the top of a 32-bit word
    wire [31:0] full_word = {next_dec_acc, 20'h0}; // [R1]
    // Round down by dropping bits below the word length
    wire [31:0] wlen_mask = (wlen == adcb_pkg::WLEN_16) ? 32'hffff0000 :
        (wlen == adcb_pkg::WLEN_20) ? 32'hfffff000 :
        (wlen == adcb_pkg::WLEN_24) ? 32'hffffff00 : 32'hffffffff;
    wire [31:0] asi_word = full_word & wlen_mask; // [R3]

    // APB answer: ready, data and error one cycle into access
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= apb_access;
            // Unmapped address errors; flag stands only with pready
            pslverr <= apb_access & ~reg_hit;
            if (apb_access)
            begin
                prdata <= pwrite ? 32'h0 : rd_mux;
            end
        end
    end

    // Pin selector and measurement control registers
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_sel <= adcb_pkg::PIN_SEL_RST;
            dc_cfg <= '{1'b0, 1'b0, adcb_pkg::DC_LEN_RST, 1'b0, 5'h00};
            freeze <= 1'b0;
        end
        else if (wr_lane0)
        begin
            if (hit_pin)
            begin
                pin_sel <= pwdata[adcb_pkg::PIN_SEL_LSB +: 4];
            end
            if (hit_dc)
            begin
                dc_cfg.enable <= pwdata[adcb_pkg::DC_EN_BIT]; // [R9]
                dc_cfg.iir <= pwdata[adcb_pkg::DC_TYPE_BIT]; // [R15]
                dc_cfg.len <= pwdata[adcb_pkg::DC_LEN_LSB +: 5]; // [R16]
            end
            if (hit_latch)
            begin
                freeze <= pwdata[adcb_pkg::LATCH_BIT]; // [R13]
                dc_cfg.prst_en <= pwdata[adcb_pkg::PRST_EN_BIT];
                dc_cfg.prst_exp <= pwdata[adcb_pkg::PRST_EXP_LSB +: 5];
            end
        end
    end

    // Front end configuration register, byte lanes honoured
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            analog_bypass <= 1'b0;
            wlen <= adcb_pkg::WLEN_RST;
            adc_oversampling_ratio <= adcb_pkg::OSR_RST;
        end
        else if (wr_go && hit_cfg)
        begin
            // Microphone mode also bypasses the analog section
            if (pstrb[0])
            begin
                analog_bypass <= pwdata[adcb_pkg::CFG_DMIC_BIT]; // [R7]
                wlen <= pwdata[adcb_pkg::CFG_WLEN_LSB +: 2];
            end
            if (pstrb[2])
            begin
                adc_oversampling_ratio[7:0] <=
                    pwdata[adcb_pkg::CFG_OSR_LSB +: 8];
            end
            if (pstrb[3])
            begin
                adc_oversampling_ratio[9:8] <=
                    pwdata[adcb_pkg::CFG_OSR_LSB + 8 +: 2];
            end
        end
    end

    // Read-back copy tracks the filter until frozen
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            held <= 24'h0;
        end
        else if (!freeze)
        begin
            // Freeze stops updates so three byte reads stay coherent
            held <= dc_result; // [R13]
        end
    end

    // Modulator clock and the multifunction pin driver
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_cnt <= 8'h00;
            modulator_clock <= 1'b0;
            multifunction_pin_one_out <= 1'b0;
            multifunction_pin_one_oe <= 1'b0;
        end
        else
        begin
            div_cnt <= div_done ? 8'h00 : div_cnt + 8'h01;
            modulator_clock <= next_modulator_clock;
            // Pin shows the clock only for the selector code
            multifunction_pin_one_out <= pin_drives_clk &
                next_modulator_clock; // [R4]
            multifunction_pin_one_oe <= pin_drives_clk; // [R4]
        end
    end

    // Two-stage synchroniser on the microphone data pin
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            din_meta <= 1'b0;
            din_sync <= 1'b0;
        end
        else
        begin
            din_meta <= serial_data_in;
            din_sync <= din_meta;
        end
    end

    // Decimator: one sample per ratio modulator periods
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dec_cnt <= 11'h000;
            dec_acc <= 12'sh000;
            asi_words <= '0;
            asi_valid <= 1'b0;
        end
        else
        begin
            asi_valid <= mod_rise & dec_done; // [R1]
            // Bit is taken at the modulator clock rising edge
            if (mod_rise)
            begin
                if (dec_done)
                begin
                    dec_cnt <= 11'h000;
                    dec_acc <= 12'sh000;
                    // Mono channel copied to both slots
                    asi_words.left <= asi_word; // [R2] [R6]
                    asi_words.right <= asi_word; // [R2]
                end
                else
                begin
                    dec_cnt <= dec_cnt + 11'h001;
                    dec_acc <= next_dec_acc; // [R6] [R21]
                end
            end
        end
    end

    // Measurement filter fed by the same modulator stream
    adcb_dc_filter u_dc_filter (
        .clk(mclk),
        .rst_b(rst_b),
        .tick(mod_rise),
        .bit_in(mod_bit),
        .cfg(dc_cfg),
        .result(dc_result)
    );

endmodule

// File: src/adcb_pkg.sv
// Shared constants and types for the ADC back end block
package adcb_pkg;

    // Core clock and the exported modulator clock
    localparam int MCLK_MHZ = 200;
    localparam int MOD_PERIOD_NS = 48;
    // Half period of the modulator clock in core cycles, rounded up
    localparam logic [7:0] MOD_HALF_CYC =
        8'((MOD_PERIOD_NS * MCLK_MHZ + 1999) / 2000);

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_PIN_SEL = 10'h033;
    localparam logic [9:0] IDX_DC_CTRL = 10'h066;
    localparam logic [9:0] IDX_DC_LATCH = 10'h067;
    localparam logic [9:0] IDX_RES_HI = 10'h068;
    localparam logic [9:0] IDX_RES_MID = 10'h069;
    localparam logic [9:0] IDX_RES_LO = 10'h06a;
    localparam logic [9:0] IDX_ADC_CFG = 10'h010;

    // Field positions
    localparam int PIN_SEL_LSB = 2;
    localparam int DC_EN_BIT = 7;
    localparam int DC_TYPE_BIT = 5;
    localparam int DC_LEN_LSB = 0;
    localparam int LATCH_BIT = 6;
    localparam int PRST_EN_BIT = 5;
    localparam int PRST_EXP_LSB = 0;
    localparam int CFG_DMIC_BIT = 0;
    localparam int CFG_WLEN_LSB = 2;
    localparam int CFG_OSR_LSB = 16;

    // Field values and reset values
    localparam logic [3:0] PIN_SEL_MODCLK = 4'ha;
    localparam logic [3:0] PIN_SEL_RST = 4'h0;
    localparam logic [4:0] DC_LEN_RST = 5'h01;
    localparam logic [4:0] DC_LEN_MIN = 5'h01;
    localparam logic [4:0] DC_LEN_MAX = 5'h14;
    localparam logic [9:0] OSR_RST = 10'h080;
    localparam logic [10:0] OSR_ZERO_MEANS = 11'h400;
    localparam logic [1:0] WLEN_RST = 2'h0;

    // Serial word length codes
    localparam logic [1:0] WLEN_16 = 2'h0;
    localparam logic [1:0] WLEN_20 = 2'h1;
    localparam logic [1:0] WLEN_24 = 2'h2;

    // Fraction bits of the 2.22 result
    localparam logic [4:0] DC_FRAC_BITS = 5'h16;

    // Left and right words handed to the serial interface
    typedef struct packed {
        logic [31:0] left;
        logic [31:0] right;
    } adcb_pair_type;

    // Measurement filter settings
    typedef struct packed {
        logic enable;
        logic iir;
        logic [4:0] len;
        logic prst_en;
        logic [4:0] prst_exp;
    } adcb_dc_cfg_type;

endpackage

// File: src/adcb_dc_filter.sv
// DC measurement filter: block average or first-order IIR
`timescale 1ns/100ps
module adcb_dc_filter (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Modulator bit stream
    input wire logic tick,
    input wire logic bit_in,
    // Settings
    input wire adcb_pkg::adcb_dc_cfg_type cfg,
    // Result in 2.22 format
    output logic [23:0] result
);

    // Block counter and running sum of +1/-1 steps
    logic [19:0] blk_cnt;
    logic signed [21:0] blk_sum;
    // Periodic reset counter, counts modulator periods
    logic [31:0] prst_cnt;
    // IIR state with guard bits
    logic signed [25:0] iir_y;

    // Clamp the length field into its legal range
    wire [4:0] len_eff = (cfg.len < adcb_pkg::DC_LEN_MIN) ?
        adcb_pkg::DC_LEN_MIN :
        (cfg.len > adcb_pkg::DC_LEN_MAX) ? adcb_pkg::DC_LEN_MAX : cfg.len;
    // Last count of a block of two to the length samples
    wire [20:0] blk_span = 21'h1 << len_eff;
    wire [19:0] blk_last = 20'(blk_span - 21'h1);
    wire blk_done = blk_cnt == blk_last;
    // One modulator bit as a signed step
    wire signed [21:0] step = bit_in ? 22'sh000001 : 22'sh3fffff;
    wire signed [21:0] sum_n = blk_sum + step;
    // Mean scaled to 22 fraction bits; full scale is exactly +/-1.0
    wire [4:0] avg_sh = adcb_pkg::DC_FRAC_BITS - len_eff;
    wire signed [23:0] avg_ext = {{2{sum_n[21]}}, sum_n};
    wire signed [23:0] avg_val = avg_ext <<< avg_sh; // [R22]
    // Periodic reset after two to the exponent periods
    wire [31:0] prst_last = (32'h1 << cfg.prst_exp) - 32'h1;
    wire prst_hit = cfg.prst_en && (prst_cnt == prst_last); // [R18]
    // IIR: y += (x - y) / 2^D, x is +/-1.0
    wire signed [25:0] iir_x = bit_in ? 26'sh0400000 : 26'sh3c00000;
    wire signed [25:0] iir_d = iir_x - iir_y;
    wire signed [25:0] iir_n = iir_y + (iir_d >>> len_eff); // [R17]

    // Filter state; everything clears while the mode is off
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            blk_cnt <= 20'h0;
            blk_sum <= 22'sh0;
            prst_cnt <= 32'h0;
            iir_y <= 26'sh0;
            result <= 24'h0;
        end
        else if (!cfg.enable)
        begin
            blk_cnt <= 20'h0;
            blk_sum <= 22'sh0;
            prst_cnt <= 32'h0;
            iir_y <= 26'sh0;
            result <= 24'h0;
        end
        else if (tick)
        begin
            // Reset counter idles at zero when disabled
            prst_cnt <= prst_hit ? 32'h0 :
                cfg.prst_en ? prst_cnt + 32'h1 : 32'h0; // [R20]
            if (cfg.iir)
            begin
                // IIR output follows every modulator period
                iir_y <= iir_n; // [R15]
                result <= 24'(iir_n); // [R11]
            end
            else
            begin
                // A reset mid-block drops the partial sum
                if (blk_done || prst_hit)
                begin
                    blk_cnt <= 20'h0;
                    blk_sum <= 22'sh0; // [R18]
                end
                else
                begin
                    blk_cnt <= blk_cnt + 20'h1;
                    blk_sum <= sum_n;
                end
                // Completed block publishes its mean
                if (blk_done)
                begin
                    result <= avg_val; // [R16] [R11]
                end
            end
        end
    end

endmodule

// File: tb/adcb_chk.sv
// Port checker for the ADC back end, bound to its top module
`timescale 1ns/100ps
module adcb_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register bus handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Multifunction pin
    input wire logic multifunction_pin_one_out,
    input wire logic multifunction_pin_one_oe,
    // Serial interface words
    input wire adcb_pkg::adcb_pair_type asi_words,
    input wire logic asi_valid
);
    // One clock domain, so clocking and disable are shared
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("bus answer not after one wait state");
    apb_pulse_a: assert property (pready |=> !pready)
        else $error("bus answer held too long");
    err_timing_a: assert property (pslverr |-> pready)
        else $error("error flag outside answer cycle");
    lr_same_a: assert property (asi_valid |->
        asi_words.left == asi_words.right)
        else $error("left and right words differ");
    word_hold_a: assert property (!asi_valid |-> $stable(asi_words))
        else $error("words changed without valid");
    rate_gap_a: assert property (asi_valid |=> !asi_valid [*8])
        else $error("word pairs too close together");
    low_bits_a: assert property (asi_valid |->
        asi_words.left[19:0] == 20'h0)
        else $error("bits below the word length not cleared");
    pin_idle_a: assert property (!multifunction_pin_one_oe |->
        !multifunction_pin_one_out)
        else $error("pin driven while not selected");
    // Exported clock high for exactly five core cycles
    clk_half_a: assert property ($rose(multifunction_pin_one_out) |->
        (multifunction_pin_one_out || !multifunction_pin_one_oe) [*5]
        ##1 (!multifunction_pin_one_out || !multifunction_pin_one_oe))
        else $error("exported clock half period wrong");

    // Main scenarios seen
    words_c: cover property (asi_valid);
    err_c: cover property (pslverr);
    pin_c: cover property ($rose(multifunction_pin_one_oe));
endmodule

bind adcb_backend adcb_chk adcb_chk_inst (.mclk, .rst_b, .psel, .penable,
    .pready, .pslverr, .multifunction_pin_one_out,
    .multifunction_pin_one_oe, .asi_words, .asi_valid);

// File: tb/adcb_mic_model.sv
// Digital microphone model on the exported modulator clock
`timescale 1ns/100ps
module adcb_mic_model (
    // Clock pin from the device
    input wire logic mod_clk,
    input wire logic mod_clk_oe,
    // Level the microphone sends, one for a run of ones
    input wire logic level,
    // One-bit stream to the device
    output logic data_out
);
    logic last_bit = 1'b0; // Last bit placed on the line

    // New bit after the falling edge, so it is settled at the rise
    always @(negedge mod_clk)
        last_bit <= level;

    // Unclocked line shows the inverse of the last bit
    assign data_out = mod_clk_oe ? last_bit : ~last_bit;
endmodule

// File: tb/adcb_backend_tb_top.sv
// Self-checking testbench for the ADC back end
`timescale 1ns/100ps
module adcb_backend_tb_top;
    logic mclk;
    logic rst_b;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic adc_mod_bit = 0; // Analog modulator bit
    logic mic_level = 1; // Level the microphone sends
    logic serial_data_in;
    logic pin_out;
    logic pin_oe;
    logic analog_bypass;
    adcb_pkg::adcb_pair_type asi_words;
    logic asi_valid;
    int fails = 0;
    int checked = 0;

    adcb_backend adcb_backend_inst (.mclk(mclk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adc_mod_bit(adc_mod_bit),
        .serial_data_in(serial_data_in),
        .multifunction_pin_one_out(pin_out),
        .multifunction_pin_one_oe(pin_oe), .analog_bypass(analog_bypass),
        .asi_words(asi_words), .asi_valid(asi_valid));

    adcb_mic_model adcb_mic_model_inst (.mod_clk(pin_out),
        .mod_clk_oe(pin_oe), .level(mic_level), .data_out(serial_data_in));

    // Core clock, 5 ns period
    initial
    begin
        mclk = 0;
        forever #2.5 mclk = ~mclk;
    end

    // Verdict and end of run
    task automatic close_out;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One bus transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [9:0] idx,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge, so a following call never drives psel twice
        @(posedge mclk);
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask

    task automatic rd(input logic [9:0] idx, input logic [31:0] exp,
        input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 32'h0, r, e);
        cmp(r, exp);
        cmp({31'h0, e}, {31'h0, exp_err});
    endtask

    // Result bytes, high byte first
    task automatic res(input logic [23:0] exp);
        rd(adcb_pkg::IDX_RES_HI, {24'h0, exp[23:16]}, 1'b0);
        rd(adcb_pkg::IDX_RES_MID, {24'h0, exp[15:8]}, 1'b0);
        rd(adcb_pkg::IDX_RES_LO, {24'h0, exp[7:0]}, 1'b0);
    endtask

    // Third word pair after a change is clean of old bits
    task automatic words(input logic [31:0] exp);
        repeat (3)
        begin
            do
                @(posedge mclk);
            while (asi_valid !== 1'b1);
        end
        cmp(asi_words.left, exp);
        cmp(asi_words.right, exp);
    endtask

    initial
    begin
        rst_b = 0;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        // Reset values and an unmapped place
        rd(adcb_pkg::IDX_DC_CTRL, 32'h1, 1'b0);
        rd(adcb_pkg::IDX_ADC_CFG, 32'h00800000, 1'b0);
        rd(adcb_pkg::IDX_PIN_SEL, 32'h0, 1'b0);
        rd(10'h3ff, 32'h0, 1'b1);
        wr(adcb_pkg::IDX_PIN_SEL,
            {26'h0, adcb_pkg::PIN_SEL_MODCLK, 2'h0});
        repeat (2) @(posedge mclk);
        cmp({31'h0, pin_oe}, 32'h1);
        $display("test regs done");
        // Microphone mode, ratio 8: sum of eight bits at the top
        wr(adcb_pkg::IDX_ADC_CFG, 32'h00080001);
        words(32'h00800000);
        cmp({31'h0, analog_bypass}, 32'h1);
        mic_level <= 1'b0;
        words(32'hff800000);
        // Analog source for every word length code
        adc_mod_bit <= 1'b1;
        for (int w = 0; w < 4; w++)
        begin
            wr(adcb_pkg::IDX_ADC_CFG, 32'h00080000 | (w << 2));
            words(32'h00800000);
        end
        $display("test stream done");
        // Measurement off gives zero
        res(24'h0);
        wr(adcb_pkg::IDX_DC_CTRL, 32'h81);
        repeat (200) @(posedge mclk);
        wr(adcb_pkg::IDX_DC_LATCH, 32'h40);
        res(24'h400000);
        adc_mod_bit <= 1'b0;
        repeat (200) @(posedge mclk);
        res(24'h400000);
        wr(adcb_pkg::IDX_DC_LATCH, 32'h0);
        res(24'hc00000);
        // First-order filter settles one step below full scale
        wr(adcb_pkg::IDX_DC_CTRL, 32'ha1);
        adc_mod_bit <= 1'b1;
        repeat (400) @(posedge mclk);
        res(24'h3fffff);
        // Reset every two ticks starves four-bit blocks
        wr(adcb_pkg::IDX_DC_CTRL, 32'h0);
        wr(adcb_pkg::IDX_DC_LATCH, 32'h21);
        wr(adcb_pkg::IDX_DC_CTRL, 32'h82);
        repeat (200) @(posedge mclk);
        res(24'h0);
        wr(adcb_pkg::IDX_DC_LATCH, 32'h01);
        repeat (200) @(posedge mclk);
        wr(adcb_pkg::IDX_RES_HI, 32'hff);
        res(24'h400000);
        // Reset exponent above the length keeps whole blocks
        wr(adcb_pkg::IDX_DC_LATCH, 32'h23);
        adc_mod_bit <= 1'b0;
        repeat (200) @(posedge mclk);
        res(24'hc00000);
        wr(adcb_pkg::IDX_PIN_SEL, 32'h0);
        repeat (2) @(posedge mclk);
        cmp({31'h0, pin_oe}, 32'h0);
        $display("test measure done");
        close_out();
    end

    // Run takes under 30 us; cut a hang well after that
    initial
    begin
        #200000;
        fails++;
        close_out();
    end
endmodule
